//--- dpcs_pkg.sv
// Constants for the deserializer pin control and status block.
// Assumes a single clock domain and a plain strobe-based register port.
package dpcs_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry
  // ----------------------------------------------------------------
  localparam int DPCS_ADDR_W = 8;
  localparam int DPCS_DATA_W = 32;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] DPCS_ADDR_STATUS     = 8'h00;
  localparam logic [7:0] DPCS_ADDR_INT_STATUS = 8'h04;
  localparam logic [7:0] DPCS_ADDR_INT_MASK   = 8'h08;
  localparam logic [7:0] DPCS_ADDR_ERR_COUNT  = 8'h0c;
  localparam logic [7:0] DPCS_ADDR_CTRL       = 8'h10;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int DPCS_STAT_LOCK      = 0;
  localparam int DPCS_STAT_PASS      = 1;
  localparam int DPCS_STAT_SELF_TEST = 2;
  localparam int DPCS_STAT_ENABLED   = 3;
  localparam int DPCS_STAT_ERR_SEEN  = 4;

  // ----------------------------------------------------------------
  // Interrupt event fields
  // ----------------------------------------------------------------
  localparam int DPCS_EV_W           = 4;
  localparam int DPCS_EV_LOCK_UP     = 0;
  localparam int DPCS_EV_LOCK_DOWN   = 1;
  localparam int DPCS_EV_PAYLOAD_ERR = 2;
  localparam int DPCS_EV_ENABLE      = 3;

  // ----------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------
  localparam int                   DPCS_CTRL_CLEAR_ERR = 0;
  localparam logic [DPCS_EV_W-1:0] DPCS_MASK_RST       = 4'h0;
  localparam logic [DPCS_EV_W-1:0] DPCS_INT_RST        = 4'h0;
  localparam logic [7:0]           DPCS_CNT_RST        = 8'h00;
  localparam logic [7:0]           DPCS_CNT_MAX        = 8'hff;
  localparam logic [7:0]           DPCS_CNT_ONE        = 8'h01;
  localparam logic [31:0]          DPCS_RD_ZERO        = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Operating states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DPCS_ST_DOWN      = 3'b001,
    DPCS_ST_NORMAL    = 3'b010,
    DPCS_ST_SELF_TEST = 3'b100
  } dpcs_state_e;

endpackage

//--- dpcs_top.sv
// Power-down, self-test mode and lock/pass status logic of the deserializer.
// Assumes all inputs are synchronous to clk_in and the host drives the
// power-down pin low until the supplies are good.

module dpcs_top
  import dpcs_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rstn_in,
  // Pins
  input  wire logic                   powerdown_bar_in,
  input  wire logic                   self_test_enable_strap,
  // Receiver status
  input  wire logic                   rx_locked_in,
  input  wire logic                   rx_port_active_in,
  input  wire logic                   pass_cond_in,
  input  wire logic                   payload_error_in,
  // Register port
  input  wire logic [DPCS_ADDR_W-1:0] addr_in,
  input  wire logic [DPCS_DATA_W-1:0] wr_data_in,
  input  wire logic                   wr_in,
  input  wire logic                   rd_in,
  output logic      [DPCS_DATA_W-1:0] rd_data_out,
  // Status outputs
  output logic                        lock_out,
  output logic                        pass_out,
  output logic                        self_test_mode,
  output logic                        irq_out
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic dpcs_hit(input logic [DPCS_ADDR_W-1:0] a,
                                    input logic [7:0]             off);
    dpcs_hit = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // Mode and status state
  // ----------------------------------------------------------------
  dpcs_state_e state;
  dpcs_state_e next_state;
  logic        err_seen;
  logic        next_err_seen;
  logic        next_lock_out;
  logic        next_pass_out;
  logic        next_self_test_mode;
  logic        clear_err;

  assign clear_err = wr_in && dpcs_hit(addr_in, DPCS_ADDR_CTRL)
                     && wr_data_in[DPCS_CTRL_CLEAR_ERR];

  always_comb begin
    next_state = state;
    if (!powerdown_bar_in) begin
      next_state = DPCS_ST_DOWN;
    end else begin
      case (state)
        DPCS_ST_DOWN: begin
          next_state = self_test_enable_strap ? DPCS_ST_SELF_TEST : DPCS_ST_NORMAL;
        end
        DPCS_ST_NORMAL: begin
          if (self_test_enable_strap) begin
            next_state = DPCS_ST_SELF_TEST;
          end
        end
        DPCS_ST_SELF_TEST: begin
          if (!self_test_enable_strap) begin
            next_state = DPCS_ST_NORMAL;
          end
        end
        default: begin
          next_state = DPCS_ST_DOWN;
        end
      endcase
    end

    next_err_seen = err_seen;
    if (!powerdown_bar_in || state != DPCS_ST_SELF_TEST || clear_err) begin
      next_err_seen = 1'b0;
    end
    if (powerdown_bar_in && state == DPCS_ST_SELF_TEST && payload_error_in) begin
      next_err_seen = 1'b1;
    end

    next_lock_out = powerdown_bar_in && state != DPCS_ST_DOWN
                    && rx_locked_in && rx_port_active_in;

    next_pass_out = 1'b0;
    if (powerdown_bar_in && state == DPCS_ST_NORMAL) begin
      next_pass_out = pass_cond_in;
    end else if (powerdown_bar_in && state == DPCS_ST_SELF_TEST) begin
      if (next_state == DPCS_ST_SELF_TEST) begin
        next_pass_out = !next_err_seen;
      end else begin
        next_pass_out = pass_cond_in;
      end
    end

    next_self_test_mode = (next_state == DPCS_ST_SELF_TEST);
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state          <= DPCS_ST_DOWN;
      err_seen       <= 1'b0;
      lock_out       <= 1'b0;
      pass_out       <= 1'b0;
      self_test_mode <= 1'b0;
    end else begin
      state          <= next_state;
      err_seen       <= next_err_seen;
      lock_out       <= next_lock_out;
      pass_out       <= next_pass_out;
      self_test_mode <= next_self_test_mode;
    end
  end

  // ----------------------------------------------------------------
  // Registers and interrupt
  // ----------------------------------------------------------------
  logic [DPCS_EV_W-1:0]   int_status;
  logic [DPCS_EV_W-1:0]   next_int_status;
  logic [DPCS_EV_W-1:0]   int_mask;
  logic [DPCS_EV_W-1:0]   next_int_mask;
  logic [7:0]             err_count;
  logic [7:0]             next_err_count;
  logic [DPCS_DATA_W-1:0] next_rd_data_out;
  logic                   next_irq_out;
  logic [DPCS_EV_W-1:0]   events;

  always_comb begin
    events = DPCS_INT_RST;
    events[DPCS_EV_LOCK_UP]     = next_lock_out && !lock_out;
    events[DPCS_EV_LOCK_DOWN]   = !next_lock_out && lock_out;
    events[DPCS_EV_PAYLOAD_ERR] = powerdown_bar_in && state == DPCS_ST_SELF_TEST
                                  && payload_error_in;
    events[DPCS_EV_ENABLE]      = powerdown_bar_in && state == DPCS_ST_DOWN;

    next_int_mask   = int_mask;
    next_int_status = int_status;
    next_err_count  = err_count;
    if (wr_in && dpcs_hit(addr_in, DPCS_ADDR_INT_MASK)) begin
      next_int_mask = wr_data_in[DPCS_EV_W-1:0];
    end
    if (wr_in && dpcs_hit(addr_in, DPCS_ADDR_INT_STATUS)) begin
      next_int_status = int_status & ~wr_data_in[DPCS_EV_W-1:0];
    end
    next_int_status = next_int_status | events;
    if (clear_err) begin
      next_err_count = DPCS_CNT_RST;
    end
    if (events[DPCS_EV_PAYLOAD_ERR] && next_err_count != DPCS_CNT_MAX) begin
      next_err_count = next_err_count + DPCS_CNT_ONE;
    end
    if (!powerdown_bar_in) begin
      next_int_mask   = DPCS_MASK_RST;
      next_int_status = DPCS_INT_RST;
      next_err_count  = DPCS_CNT_RST;
    end

    next_rd_data_out = DPCS_RD_ZERO;
    if (rd_in) begin
      if (dpcs_hit(addr_in, DPCS_ADDR_STATUS)) begin
        next_rd_data_out[DPCS_STAT_LOCK]      = lock_out;
        next_rd_data_out[DPCS_STAT_PASS]      = pass_out;
        next_rd_data_out[DPCS_STAT_SELF_TEST] = self_test_mode;
        next_rd_data_out[DPCS_STAT_ENABLED]   = (state != DPCS_ST_DOWN);
        next_rd_data_out[DPCS_STAT_ERR_SEEN]  = err_seen;
      end else if (dpcs_hit(addr_in, DPCS_ADDR_INT_STATUS)) begin
        next_rd_data_out[DPCS_EV_W-1:0] = int_status;
      end else if (dpcs_hit(addr_in, DPCS_ADDR_INT_MASK)) begin
        next_rd_data_out[DPCS_EV_W-1:0] = int_mask;
      end else if (dpcs_hit(addr_in, DPCS_ADDR_ERR_COUNT)) begin
        next_rd_data_out[7:0] = err_count;
      end
    end

    next_irq_out = |(next_int_status & next_int_mask);
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      int_status  <= DPCS_INT_RST;
      int_mask    <= DPCS_MASK_RST;
      err_count   <= DPCS_CNT_RST;
      rd_data_out <= DPCS_RD_ZERO;
      irq_out     <= 1'b0;
    end else begin
      int_status  <= next_int_status;
      int_mask    <= next_int_mask;
      err_count   <= next_err_count;
      rd_data_out <= next_rd_data_out;
      irq_out     <= next_irq_out;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking dpcs_cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  a_down_holds_defaults: assert property (
    !powerdown_bar_in |=> (state == DPCS_ST_DOWN) && (int_status == DPCS_INT_RST)
                          && (int_mask == DPCS_MASK_RST) && !self_test_mode)
    else $error("power-down did not hold defaults");

  a_enable_from_default: assert property (
    $rose(powerdown_bar_in) |-> (state == DPCS_ST_DOWN) && (err_count == DPCS_CNT_RST)
                                ##1 (state != DPCS_ST_DOWN))
    else $error("enable did not start from defaults");

  a_down_outputs_low: assert property (
    !powerdown_bar_in [*2] |-> !lock_out && !pass_out)
    else $error("status output high while powered down");

  a_strap_mode_on: assert property (
    powerdown_bar_in && self_test_enable_strap |=> self_test_mode)
    else $error("strap high did not select self-test");

  a_strap_mode_off: assert property (
    !self_test_enable_strap |=> !self_test_mode)
    else $error("self-test active with strap low");

  a_lock_lost: assert property (
    !rx_locked_in |=> !lock_out)
    else $error("lock high while receiver unlocked");

  a_lock_gained: assert property (
    powerdown_bar_in && (state != DPCS_ST_DOWN) && rx_locked_in && rx_port_active_in
    |=> lock_out)
    else $error("lock low while locked and active");

  a_pass_normal: assert property (
    powerdown_bar_in && (state == DPCS_ST_NORMAL) && !self_test_enable_strap
    |=> pass_out == $past(pass_cond_in))
    else $error("pass did not follow pass conditions");

  a_pass_clean: assert property (
    powerdown_bar_in && (state == DPCS_ST_SELF_TEST) && self_test_enable_strap
    && !err_seen && !payload_error_in |=> pass_out)
    else $error("pass low during error-free self-test");

  a_pass_error: assert property (
    powerdown_bar_in && (state == DPCS_ST_SELF_TEST) && self_test_enable_strap
    && payload_error_in ##1 powerdown_bar_in && self_test_enable_strap && !clear_err
    |-> !pass_out [*2])
    else $error("pass stayed high after payload error");

  a_irq_level: assert property (
    irq_out == |(int_status & int_mask))
    else $error("interrupt output disagrees with status and mask");

  a_read_idle_zero: assert property (
    !$past(rd_in) |-> rd_data_out == DPCS_RD_ZERO)
    else $error("read data not zero outside read answer");

  a_enable_flag_set: assert property (
    powerdown_bar_in && (state == DPCS_ST_DOWN) |=> int_status[DPCS_EV_ENABLE])
    else $error("enable event not flagged");

  a_lock_needs_active: assert property (
    !rx_port_active_in |=> !lock_out)
    else $error("lock high while receive port inactive");

  a_lock_rise_flag: assert property (
    $rose(lock_out) |-> int_status[DPCS_EV_LOCK_UP])
    else $error("lock rise not flagged");

  a_normal_count_held: assert property (
    powerdown_bar_in && (state == DPCS_ST_NORMAL) && !clear_err |=> $stable(err_count))
    else $error("error count moved outside self-test");

  a_err_count_step: assert property (
    events[DPCS_EV_PAYLOAD_ERR] && (err_count != DPCS_CNT_MAX) |=> err_count != DPCS_CNT_RST)
    else $error("payload error not counted");

  a_clear_restores: assert property (
    powerdown_bar_in && (state == DPCS_ST_SELF_TEST) && self_test_enable_strap
    && clear_err && !payload_error_in |=> pass_out)
    else $error("pass low after error clear in clean self-test");

endmodule

//--- dpcs_host_model.sv
// Host GPIO model that drives the power-down pin of the block.
// Assumes the bench reports supply state and power-down requests on clk_in.
module dpcs_host_model (
  // Clock
  input  wire logic clk_in,
  // Host side
  input  wire logic supply_ok_in,
  input  wire logic pd_req_in,
  // Pin
  output logic      powerdown_bar_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Pin held low until supplies are good
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    powerdown_bar_out <= supply_ok_in & ~pd_req_in;
  end
endmodule

//--- dpcs_top_test.sv
// Self-checking bench for the pin control and status block.
// Assumes the host model drives the power-down pin; bench drives the rest.
`define CHK(g, e) cmp(32'(g), 32'(e));
module dpcs_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dpcs_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                   clk_in = 1'b0;
  logic                   rstn_in = 1'b0;
  logic                   supply_ok = 1'b0;
  logic                   pd_req = 1'b0;
  logic                   powerdown_bar;
  logic                   strap = 1'b0;
  logic                   locked = 1'b0;
  logic                   active = 1'b0;
  logic                   pass_cond = 1'b0;
  logic                   perr = 1'b0;
  logic [DPCS_ADDR_W-1:0] addr = 8'h00;
  logic [DPCS_DATA_W-1:0] wdata = 32'h0;
  logic                   wr = 1'b0;
  logic                   rd = 1'b0;
  logic [DPCS_DATA_W-1:0] rd_data;
  logic                   lock_o;
  logic                   pass_o;
  logic                   stm;
  logic                   irq;
  int                     mismatches = 0;
  int                     check_count = 0;

  always #12.5 clk_in = ~clk_in;

  dpcs_host_model dpcs_host_model_inst (.clk_in(clk_in), .supply_ok_in(supply_ok),
    .pd_req_in(pd_req), .powerdown_bar_out(powerdown_bar));

  dpcs_top dpcs_top_inst (.clk_in(clk_in), .rstn_in(rstn_in), .powerdown_bar_in(powerdown_bar),
    .self_test_enable_strap(strap), .rx_locked_in(locked), .rx_port_active_in(active),
    .pass_cond_in(pass_cond), .payload_error_in(perr), .addr_in(addr), .wr_data_in(wdata),
    .wr_in(wr), .rd_in(rd), .rd_data_out(rd_data), .lock_out(lock_o), .pass_out(pass_o),
    .self_test_mode(stm), .irq_out(irq));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got 0x%0h expected 0x%0h", $time, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    rd <= 1'b1; addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    cmp(rd_data, e);
  endtask

  task automatic pulse_err();
    @(posedge clk_in);
    perr <= 1'b1;
    @(posedge clk_in);
    perr <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_powered_down();
    locked <= 1'b1; active <= 1'b1; pass_cond <= 1'b1;
    tick(3);
    `CHK(lock_o, 1'b0)
    `CHK(pass_o, 1'b0)
    wr_reg(DPCS_ADDR_INT_MASK, 32'hf);
    rd_chk(DPCS_ADDR_INT_MASK, 32'h0);
    rd_chk(DPCS_ADDR_STATUS, 32'h0);
  endtask

  task automatic test_release();
    supply_ok <= 1'b1;
    tick(4);
    `CHK(stm, 1'b0)
    `CHK(lock_o, 1'b1)
    `CHK(pass_o, 1'b1)
    rd_chk(DPCS_ADDR_INT_STATUS, 32'h9);
    rd_chk(DPCS_ADDR_STATUS, 32'h0b);
    rd_chk(DPCS_ADDR_ERR_COUNT, 32'h0);
  endtask

  task automatic test_normal();
    pass_cond <= 1'b0;
    pulse_err();
    tick(3);
    `CHK(pass_o, 1'b0)
    rd_chk(DPCS_ADDR_ERR_COUNT, 32'h0);
    active <= 1'b0;
    tick(3);
    `CHK(lock_o, 1'b0)
    active <= 1'b1; pass_cond <= 1'b1;
    tick(3);
    `CHK(lock_o, 1'b1)
  endtask

  task automatic test_self_test();
    strap <= 1'b1;
    wr_reg(DPCS_ADDR_INT_MASK, 32'h4);
    tick(3);
    `CHK(stm, 1'b1)
    `CHK(irq, 1'b0)
    pass_cond <= 1'b0;
    tick(3);
    `CHK(pass_o, 1'b1)
    pulse_err();
    tick(3);
    `CHK(pass_o, 1'b0)
    `CHK(irq, 1'b1)
    rd_chk(DPCS_ADDR_STATUS, 32'h1d);
    rd_chk(DPCS_ADDR_ERR_COUNT, 32'h1);
    wr_reg(DPCS_ADDR_INT_STATUS, 32'h4);
    tick(2);
    `CHK(irq, 1'b0)
    `CHK(pass_o, 1'b0)
    @(posedge clk_in);
    perr <= 1'b1;
    wr <= 1'b1;
    addr <= DPCS_ADDR_CTRL;
    wdata <= 32'h1;
    @(posedge clk_in);
    perr <= 1'b0;
    wr <= 1'b0;
    tick(2);
    `CHK(pass_o, 1'b0)
    `CHK(irq, 1'b1)
    rd_chk(DPCS_ADDR_ERR_COUNT, 32'h1);
    wr_reg(DPCS_ADDR_CTRL, 32'h1);
    tick(2);
    `CHK(pass_o, 1'b1)
    rd_chk(DPCS_ADDR_ERR_COUNT, 32'h0);
    rd_chk(DPCS_ADDR_STATUS, 32'h0f);
  endtask

  task automatic test_power_cycle();
    pd_req <= 1'b1;
    tick(4);
    `CHK({lock_o, pass_o, stm}, 3'b000)
    rd_chk(DPCS_ADDR_INT_MASK, 32'h0);
    pd_req <= 1'b0;
    tick(4);
    `CHK(stm, 1'b1)
    `CHK(pass_o, 1'b1)
    rd_chk(DPCS_ADDR_ERR_COUNT, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #(2000 * 25);
    mismatches++;
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    test_powered_down();
    test_release();
    test_normal();
    test_self_test();
    test_power_cycle();
    print_verdict();
  end
endmodule
